/* File: include/mps_cfg.svh */
// Timing constants for the module power-off and reset sequencer.
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH
`define MPS_CLK_HZ         32'h05f5e100
`define MPS_TICK_HZ        32'h000003e8
`define MPS_KEY_OFF_MS     16'h03e8
`define MPS_KEY_ON_MS      16'h0064
`define MPS_RST_ON_MS      16'h0032
`define MPS_MUX_EXTRA_MS   16'h09c4
`define MPS_PIN_HOLD_MS    16'h0bb8
`define MPS_OFF_ROUTINE_MS 16'h00c8
`define MPS_SAVE_MS        16'h0064
`define MPS_BOOT_RST_MS    16'h0064
`define MPS_RESP_TO_MS     16'h2710
`define MPS_DEB_MS         16'h0002
`endif

/* File: include/mps_pkg.sv */
// Types shared by both ends of the power sequencing link.
package mps_pkg;
   typedef enum logic [1:0] {
      cmd_power_off,
      cmd_function_reset,
      cmd_thermal_supervisor
   } mps_cmd_t;
   typedef enum logic [2:0] {
      ds_no_power,
      ds_power_off,
      ds_reset_arm,
      ds_reset_held,
      ds_boot,
      ds_on,
      ds_off_routine,
      ds_save
   } mps_dev_state_t;
   typedef enum logic [3:0] {
      hs_no_supply,
      hs_off,
      hs_key_on,
      hs_boot,
      hs_ready,
      hs_key_off,
      hs_cmd,
      hs_wait_off,
      hs_rst
   } mps_host_state_t;
   typedef enum logic [3:0] {
      op_supply_on,
      op_supply_off,
      op_start_key,
      op_start_rst,
      op_off_key,
      op_off_cmd,
      op_reset_cmd,
      op_thermal_cmd,
      op_hw_reset
   } mps_op_t;
endpackage : mps_pkg

/* File: include/mps_link_if.sv */
// Link between host and module: supply, open-drain key and reset, commands, sense lines.
`timescale 1ns/100ps
interface mps_link_if;
   logic              main_supply_on;
   logic              power_key_o;
   logic              power_key_oe;
   logic              reset_o;
   logic              reset_oe;
   logic              power_key_input_n;
   logic              reset_input_n;
   logic              cmd_valid;
   mps_pkg::mps_cmd_t cmd_op;
   logic              cmd_arg;
   logic              resp_ok;
   logic              interface_supply;
   logic              backup_clock_supply;
   logic              dev_pins_oe;
   logic              host_pins_oe;

   // Open-drain lines with pull-ups: low only while the host drives a low.
   assign power_key_input_n = !(power_key_oe && !power_key_o);
   assign reset_input_n     = !(reset_oe && !reset_o);

   modport dev_mp (
      input  main_supply_on, power_key_input_n, reset_input_n, cmd_valid, cmd_op, cmd_arg, host_pins_oe,
      output resp_ok, interface_supply, backup_clock_supply, dev_pins_oe
   );
   modport host_mp (
      output main_supply_on, power_key_o, power_key_oe, reset_o, reset_oe, cmd_valid, cmd_op, cmd_arg,
      output host_pins_oe,
      input  resp_ok, interface_supply, backup_clock_supply, dev_pins_oe
   );
endinterface : mps_link_if

/* File: rtl/mps_device.sv */
// Module end: power-on, orderly and abrupt power-off, software and hardware reset.
`timescale 1ns/100ps
`include "mps_cfg.svh"
module mps_device #(
   parameter int unsigned TICK_CYCLES    = `MPS_CLK_HZ / `MPS_TICK_HZ,
   parameter logic [15:0] KEY_OFF_MS     = `MPS_KEY_OFF_MS,
   parameter logic [15:0] RST_ON_MS      = `MPS_RST_ON_MS,
   parameter logic [15:0] MUX_EXTRA_MS   = `MPS_MUX_EXTRA_MS,
   parameter logic [15:0] OFF_ROUTINE_MS = `MPS_OFF_ROUTINE_MS,
   parameter logic [15:0] SAVE_MS        = `MPS_SAVE_MS,
   parameter logic [15:0] BOOT_RST_MS    = `MPS_BOOT_RST_MS
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   mps_link_if.dev_mp            link,
   input  wire logic             temp_danger,
   output logic                  core_rst_n,
   output logic                  clean_off_done,
   output logic                  abrupt_off,
   output mps_pkg::mps_dev_state_t dev_state
);
   localparam int unsigned TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   generate
      if (TICK_CYCLES < 2) begin : g_bad_tick
         $error("TICK_CYCLES must be at least 2.");
      end
   endgenerate

   mps_pkg::mps_dev_state_t state_q, state_d;
   logic [TW-1:0]           div_q;
   logic [15:0]             ms_q;
   logic [15:0]             key_ms_q;
   logic                    vcc_s1_q, vcc_s2_q, key_s1_q, key_s2_q, rst_s1_q, rst_s2_q;
   logic                    mux_q, thermal_en_q;
   logic                    vint_q, pins_q, backup_q, core_rst_n_q, resp_q, clean_q, abrupt_q;

   wire tick       = (div_q == TW'(TICK_CYCLES - 1));
   wire st_change  = (state_d != state_q);
   wire active     = (state_q == mps_pkg::ds_boot) || (state_q == mps_pkg::ds_on) ||
                     (state_q == mps_pkg::ds_off_routine) || (state_q == mps_pkg::ds_save);
   wire cmd_take   = link.cmd_valid && (state_q == mps_pkg::ds_on);
   wire cmd_off    = cmd_take && (link.cmd_op == mps_pkg::cmd_power_off);
   wire cmd_reset  = cmd_take && (link.cmd_op == mps_pkg::cmd_function_reset);
   wire cmd_therm  = cmd_take && (link.cmd_op == mps_pkg::cmd_thermal_supervisor);
   wire key_long   = (key_ms_q >= KEY_OFF_MS);
   wire therm_trip = thermal_en_q && temp_danger;
   wire [16:0] off_len  = {1'b0, OFF_ROUTINE_MS} + (mux_q ? {1'b0, MUX_EXTRA_MS} : 17'h00000);
   wire        off_end  = ({1'b0, ms_q} > off_len);
   wire        rst_low  = !rst_s2_q;
   wire        vcc_ok   = vcc_s2_q;

   // Synchronisers for the supply, key and reset lines.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         vcc_s1_q <= 1'b0;
         vcc_s2_q <= 1'b0;
         key_s1_q <= 1'b1;
         key_s2_q <= 1'b1;
         rst_s1_q <= 1'b1;
         rst_s2_q <= 1'b1;
      end else begin
         vcc_s1_q <= link.main_supply_on;
         vcc_s2_q <= vcc_s1_q;
         key_s1_q <= link.power_key_input_n;
         key_s2_q <= key_s1_q;
         rst_s1_q <= link.reset_input_n;
         rst_s2_q <= rst_s1_q;
      end
   end

   // Millisecond tick divider and phase timers.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_q    <= '0;
         ms_q     <= 16'h0000;
         key_ms_q <= 16'h0000;
      end else begin
         div_q    <= tick ? '0 : div_q + TW'(1);
         ms_q     <= st_change ? 16'h0000 : ((tick && ms_q != 16'hffff) ? ms_q + 16'h0001 : ms_q);
         key_ms_q <= (key_s2_q || state_q != mps_pkg::ds_on) ? 16'h0000 :
                     ((tick && key_ms_q != 16'hffff) ? key_ms_q + 16'h0001 : key_ms_q);
      end
   end

   always_comb begin
      state_d = state_q;
      if (!vcc_ok) begin
         state_d = mps_pkg::ds_no_power;
      end else begin
         unique case (state_q)
            mps_pkg::ds_no_power: begin
               state_d = mps_pkg::ds_boot;
            end
            mps_pkg::ds_power_off: begin
               if (rst_low) begin
                  state_d = mps_pkg::ds_reset_arm;
               end else if (!key_s2_q) begin
                  state_d = mps_pkg::ds_boot;
               end
            end
            mps_pkg::ds_reset_arm: begin
               // Reset pulse must be long enough.
               if (!rst_low) begin
                  state_d = (ms_q >= RST_ON_MS) ? mps_pkg::ds_boot : mps_pkg::ds_power_off;
               end
            end
            mps_pkg::ds_reset_held: begin
               if (!rst_low) begin
                  state_d = mps_pkg::ds_boot;
               end
            end
            mps_pkg::ds_boot: begin
               if (rst_low) begin
                  state_d = mps_pkg::ds_reset_held;
               end else if (ms_q > BOOT_RST_MS) begin
                  state_d = mps_pkg::ds_on;
               end
            end
            mps_pkg::ds_on: begin
               if (rst_low) begin
                  state_d = mps_pkg::ds_reset_held;
               end else if (cmd_off || key_long || therm_trip) begin
                  state_d = mps_pkg::ds_off_routine;
               end else if (cmd_reset) begin
                  state_d = mps_pkg::ds_save;
               end
            end
            mps_pkg::ds_off_routine: begin
               if (rst_low) begin
                  state_d = mps_pkg::ds_reset_held;
               end else if (off_end) begin
                  state_d = mps_pkg::ds_power_off;
               end
            end
            mps_pkg::ds_save: begin
               if (rst_low) begin
                  state_d = mps_pkg::ds_reset_held;
               end else if (ms_q > SAVE_MS) begin
                  state_d = mps_pkg::ds_boot;
               end
            end
         endcase
      end
   end

   // Supplies and pin drive follow the state.
   wire vint_d   = (state_d == mps_pkg::ds_boot) || (state_d == mps_pkg::ds_on) ||
                   (state_d == mps_pkg::ds_off_routine) || (state_d == mps_pkg::ds_save);
   wire run_d    = (state_d == mps_pkg::ds_on) || (state_d == mps_pkg::ds_off_routine) ||
                   (state_d == mps_pkg::ds_save);
   // Hardware reset drops supply and pins.
   wire abrupt_d = active && (!vcc_ok || rst_low);
   wire clean_d  = (state_q == mps_pkg::ds_off_routine && state_d == mps_pkg::ds_power_off) ||
                   (state_q == mps_pkg::ds_save && state_d == mps_pkg::ds_boot);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q      <= mps_pkg::ds_no_power;
         mux_q        <= 1'b0;
         thermal_en_q <= 1'b0;
         vint_q       <= 1'b0;
         pins_q       <= 1'b0;
         backup_q     <= 1'b0;
         core_rst_n_q <= 1'b0;
         resp_q       <= 1'b0;
         clean_q      <= 1'b0;
         abrupt_q     <= 1'b0;
      end else begin
         state_q      <= state_d;
         mux_q        <= (state_q == mps_pkg::ds_on) ? (cmd_off && link.cmd_arg) : mux_q;
         thermal_en_q <= !vint_d ? 1'b0 : (cmd_therm ? link.cmd_arg : thermal_en_q);
         vint_q       <= vint_d;
         pins_q       <= run_d;
         backup_q     <= (state_d != mps_pkg::ds_no_power);
         core_rst_n_q <= run_d;
         // Answer OK one cycle after any command taken in ds_on, thermal supervisor included.
         resp_q       <= cmd_take;
         clean_q      <= clean_d;
         abrupt_q     <= abrupt_d;
      end
   end

   assign link.interface_supply    = vint_q;
   assign link.dev_pins_oe         = pins_q;
   assign link.backup_clock_supply = backup_q;
   assign link.resp_ok             = resp_q;
   assign core_rst_n               = core_rst_n_q;
   assign clean_off_done           = clean_q;
   assign abrupt_off               = abrupt_q;
   assign dev_state                = state_q;
endmodule : mps_device

/* File: rtl/mps_host.sv */
// Host end: supply control, key and reset pulses, commands and safe pin release.
`timescale 1ns/100ps
`include "mps_cfg.svh"
module mps_host #(
   parameter int unsigned TICK_CYCLES  = `MPS_CLK_HZ / `MPS_TICK_HZ,
   parameter logic [15:0] KEY_OFF_MS   = `MPS_KEY_OFF_MS,
   parameter logic [15:0] KEY_ON_MS    = `MPS_KEY_ON_MS,
   parameter logic [15:0] RST_ON_MS    = `MPS_RST_ON_MS,
   parameter logic [15:0] MUX_EXTRA_MS = `MPS_MUX_EXTRA_MS,
   parameter logic [15:0] PIN_HOLD_MS  = `MPS_PIN_HOLD_MS,
   parameter logic [15:0] RESP_TO_MS   = `MPS_RESP_TO_MS,
   parameter logic [15:0] DEB_MS       = `MPS_DEB_MS
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   mps_link_if.host_mp           link,
   input  wire logic             req_valid,
   input  wire mps_pkg::mps_op_t req_op,
   input  wire logic             req_arg,
   output logic                  req_ready,
   output logic                  module_up,
   output logic                  cmd_fail,
   output mps_pkg::mps_host_state_t host_state
);
   localparam int unsigned TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   generate
      if (TICK_CYCLES < 2) begin : g_bad_tick
         $error("TICK_CYCLES must be at least 2.");
      end
   endgenerate

   mps_pkg::mps_host_state_t state_q, state_d;
   logic [TW-1:0]            div_q;
   logic [15:0]              ms_q, deb_q;
   logic                     vint_s1_q, vint_s2_q, vint_ok_q;
   logic                     vcc_q, cmd_v_q, cmd_arg_q, mux_q, ready_q, up_q, fail_q, pins_q;
   logic                     key_oe_q, rst_oe_q;
   mps_pkg::mps_cmd_t        cmd_op_q, cmd_op_d;

   wire tick      = (div_q == TW'(TICK_CYCLES - 1));
   wire st_change = (state_d != state_q);
   wire take      = req_valid && ready_q;
   wire timeout   = (ms_q > RESP_TO_MS);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         vint_s1_q <= 1'b0;
         vint_s2_q <= 1'b0;
         vint_ok_q <= 1'b0;
         deb_q     <= 16'h0000;
         div_q     <= '0;
         ms_q      <= 16'h0000;
      end else begin
         vint_s1_q <= link.interface_supply;
         vint_s2_q <= vint_s1_q;
         // Sense is accepted only once stable.
         deb_q     <= (vint_s2_q == vint_ok_q) ? 16'h0000 : (tick ? deb_q + 16'h0001 : deb_q);
         vint_ok_q <= (deb_q > DEB_MS) ? vint_s2_q : vint_ok_q;
         div_q     <= tick ? '0 : div_q + TW'(1);
         ms_q      <= st_change ? 16'h0000 : ((tick && ms_q != 16'hffff) ? ms_q + 16'h0001 : ms_q);
      end
   end

   always_comb begin
      state_d  = state_q;
      cmd_op_d = cmd_op_q;
      unique case (state_q)
         mps_pkg::hs_no_supply: begin
            if (take && req_op == mps_pkg::op_supply_on) begin
               state_d = mps_pkg::hs_boot;
            end
         end
         mps_pkg::hs_off: begin
            if (take && req_op == mps_pkg::op_supply_off) begin
               state_d = mps_pkg::hs_no_supply;
            end else if (take && req_op == mps_pkg::op_start_key) begin
               state_d = mps_pkg::hs_key_on;
            end else if (take && req_op == mps_pkg::op_start_rst) begin
               state_d = mps_pkg::hs_rst;
            end
         end
         mps_pkg::hs_key_on: begin
            if (ms_q > KEY_ON_MS) begin
               state_d = mps_pkg::hs_boot;
            end
         end
         mps_pkg::hs_boot: begin
            // Pins released only after the hold time.
            if (vint_ok_q && ms_q > PIN_HOLD_MS) begin
               state_d = mps_pkg::hs_ready;
            end
         end
         mps_pkg::hs_ready: begin
            if (take && req_op == mps_pkg::op_off_key) begin
               state_d = mps_pkg::hs_key_off;
            end else if (take && req_op == mps_pkg::op_hw_reset) begin
               state_d = mps_pkg::hs_rst;
            end else if (take && req_op == mps_pkg::op_off_cmd) begin
               state_d  = mps_pkg::hs_cmd;
               cmd_op_d = mps_pkg::cmd_power_off;
            end else if (take && req_op == mps_pkg::op_reset_cmd) begin
               state_d  = mps_pkg::hs_cmd;
               cmd_op_d = mps_pkg::cmd_function_reset;
            end else if (take && req_op == mps_pkg::op_thermal_cmd) begin
               state_d  = mps_pkg::hs_cmd;
               cmd_op_d = mps_pkg::cmd_thermal_supervisor;
            end
         end
         mps_pkg::hs_key_off: begin
            // Hold the key low past one second.
            if (ms_q > KEY_OFF_MS) begin
               state_d = mps_pkg::hs_wait_off;
            end
         end
         mps_pkg::hs_cmd: begin
            if (link.resp_ok) begin
               unique case (cmd_op_q)
                  mps_pkg::cmd_power_off:      state_d = mps_pkg::hs_wait_off;
                  mps_pkg::cmd_function_reset: state_d = mps_pkg::hs_boot;
                  default:                     state_d = mps_pkg::hs_ready;
               endcase
            // No reply in time forces a hardware reset.
            end else if (timeout) begin
               state_d = mps_pkg::hs_rst;
            end
         end
         mps_pkg::hs_wait_off: begin
            if (!vint_ok_q && (!mux_q || ms_q > MUX_EXTRA_MS)) begin
               state_d = mps_pkg::hs_off;
            end
         end
         mps_pkg::hs_rst: begin
            if (ms_q > RST_ON_MS) begin
               state_d = mps_pkg::hs_boot;
            end
         end
         default: begin
            state_d = mps_pkg::hs_no_supply;
         end
      endcase
   end

   // Supply held except in the no-supply state.
   wire vcc_d   = (state_d != mps_pkg::hs_no_supply);
   wire ready_d = (state_d == mps_pkg::hs_no_supply) || (state_d == mps_pkg::hs_off) ||
                  (state_d == mps_pkg::hs_ready);
   wire pins_d  = (state_d == mps_pkg::hs_ready) || (state_d == mps_pkg::hs_cmd) ||
                  (state_d == mps_pkg::hs_key_off);
   wire key_oe_d = (state_d == mps_pkg::hs_key_on) || (state_d == mps_pkg::hs_key_off);
   wire rst_oe_d = (state_d == mps_pkg::hs_rst);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q   <= mps_pkg::hs_no_supply;
         cmd_op_q  <= mps_pkg::cmd_power_off;
         cmd_v_q   <= 1'b0;
         cmd_arg_q <= 1'b0;
         mux_q     <= 1'b0;
         vcc_q     <= 1'b0;
         ready_q   <= 1'b0;
         up_q      <= 1'b0;
         fail_q    <= 1'b0;
         pins_q    <= 1'b0;
         key_oe_q  <= 1'b0;
         rst_oe_q  <= 1'b0;
      end else begin
         state_q   <= state_d;
         cmd_op_q  <= cmd_op_d;
         cmd_v_q   <= (state_q == mps_pkg::hs_ready) && (state_d == mps_pkg::hs_cmd);
         cmd_arg_q <= take ? req_arg : cmd_arg_q;
         mux_q     <= (take && req_op == mps_pkg::op_off_cmd) ? req_arg :
                      ((take && req_op == mps_pkg::op_off_key) ? 1'b0 : mux_q);
         vcc_q     <= vcc_d;
         ready_q   <= ready_d;
         up_q      <= (state_d == mps_pkg::hs_ready);
         fail_q    <= (state_q == mps_pkg::hs_cmd) && !link.resp_ok && timeout;
         pins_q    <= pins_d;
         key_oe_q  <= key_oe_d;
         rst_oe_q  <= rst_oe_d;
      end
   end

   assign link.main_supply_on = vcc_q;
   assign link.power_key_o    = 1'b0;
   assign link.power_key_oe   = key_oe_q;
   assign link.reset_o        = 1'b0;
   assign link.reset_oe       = rst_oe_q;
   assign link.cmd_valid      = cmd_v_q;
   assign link.cmd_op         = cmd_op_q;
   assign link.cmd_arg        = cmd_arg_q;
   assign link.host_pins_oe   = pins_q;
   assign req_ready           = ready_q;
   assign module_up           = up_q;
   assign cmd_fail            = fail_q;
   assign host_state          = state_q;
endmodule : mps_host

/* File: test/mps_link_chk.sv */
// Concurrent checks on the link between host end and module end.
`timescale 1ns/100ps
module mps_link_chk (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic main_supply_on,
   input wire logic power_key_input_n,
   input wire logic reset_input_n,
   input wire logic cmd_valid,
   input wire logic resp_ok,
   input wire logic interface_supply,
   input wire logic backup_clock_supply,
   input wire logic dev_pins_oe,
   input wire logic host_pins_oe
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   a_resp_single: assert property (resp_ok |=> !resp_ok)
      else $error("resp_ok too long");
   a_resp_cause: assert property (resp_ok |-> $past(cmd_valid) || $past(cmd_valid, 2))
      else $error("resp_ok without command");
   a_pins_need_supply: assert property (dev_pins_oe |-> interface_supply)
      else $error("pins driven without supply");
   a_backup_loss: assert property ($fell(main_supply_on) |-> ##[1:5] !backup_clock_supply)
      else $error("backup kept after supply loss");
   a_reset_cuts: assert property (!reset_input_n && interface_supply |->
      ##[1:5] !(interface_supply || dev_pins_oe))
      else $error("supply kept in reset");
   a_key_width: assert property ($fell(power_key_input_n) |-> !power_key_input_n [*8])
      else $error("key pulse short");
   a_reset_width: assert property ($fell(reset_input_n) |-> !reset_input_n [*8])
      else $error("reset pulse short");
   a_host_pins_rst: assert property (!reset_input_n [*2] |-> !host_pins_oe)
      else $error("host pins driven in reset");
   a_pins_settle: assert property ($rose(host_pins_oe) |-> interface_supply && $past(interface_supply, 8))
      else $error("host pins before supply settled");
   a_supply_kept: assert property ($fell(main_supply_on) |-> !$past(interface_supply))
      else $error("supply removed too early");
endmodule : mps_link_chk

/* File: test/module_power_off_reset_sequencer_tb.sv */
// Bench joining host end and module end over one link.
`timescale 1ns/100ps
module module_power_off_reset_sequencer_tb;
   localparam int TK = 4;
   localparam logic [15:0] KOFF = 16'h000a, KON = 16'h0002, RSTW = 16'h0005, MUX = 16'h0008;
   localparam logic [15:0] HOLD = 16'h000c, ROUT = 16'h0006, SAVE = 16'h0004, BOOT = 16'h0004;
   localparam logic [15:0] RESP = 16'h0028, DEB = 16'h0002;
   logic                     core_clk = 1'b0;
   logic                     sys_rst = 1'b1;
   logic                     req_valid = 1'b0;
   mps_pkg::mps_op_t         req_op = mps_pkg::op_supply_on;
   logic                     req_arg = 1'b0;
   logic                     temp_danger = 1'b0;
   logic                     req_ready, module_up, cmd_fail, core_rst_n, clean_off_done, abrupt_off;
   mps_pkg::mps_dev_state_t  dev_state;
   mps_pkg::mps_host_state_t host_state;
   logic [31:0]              seed = 32'h0000c95c;
   int                       fail_count = 0, n_checks = 0, n_clean = 0, n_abrupt = 0;
   int                       n_core = 0, n_resp = 0, n_low = 0, n_fail = 0, t, c0, c1, c2;

   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (clean_off_done === 1'b1) n_clean <= n_clean + 1;
      if (abrupt_off === 1'b1) n_abrupt <= n_abrupt + 1;
      if (core_rst_n === 1'b0) n_core <= n_core + 1;
      if (link.resp_ok === 1'b1) n_resp <= n_resp + 1;
      if (link.interface_supply === 1'b0) n_low <= n_low + 1;
      if (cmd_fail === 1'b1) n_fail <= n_fail + 1;
   end

   mps_link_if link ();
   mps_device #(.TICK_CYCLES(TK), .KEY_OFF_MS(KOFF), .RST_ON_MS(RSTW), .MUX_EXTRA_MS(MUX),
                .OFF_ROUTINE_MS(ROUT), .SAVE_MS(SAVE), .BOOT_RST_MS(BOOT)) u_mps_device (
      .core_clk, .sys_rst, .link(link.dev_mp), .temp_danger, .core_rst_n, .clean_off_done, .abrupt_off, .dev_state);
   mps_host #(.TICK_CYCLES(TK), .KEY_OFF_MS(KOFF), .KEY_ON_MS(KON), .RST_ON_MS(RSTW),
              .MUX_EXTRA_MS(MUX), .PIN_HOLD_MS(HOLD), .RESP_TO_MS(RESP), .DEB_MS(DEB)) u_mps_host (
      .core_clk, .sys_rst, .link(link.host_mp), .req_valid, .req_op, .req_arg, .req_ready, .module_up, .cmd_fail,
      .host_state);
   mps_link_chk u_mps_link_chk (.core_clk, .sys_rst, .main_supply_on(link.main_supply_on),
      .power_key_input_n(link.power_key_input_n), .reset_input_n(link.reset_input_n), .cmd_valid(link.cmd_valid),
      .resp_ok(link.resp_ok), .interface_supply(link.interface_supply),
      .backup_clock_supply(link.backup_clock_supply), .dev_pins_oe(link.dev_pins_oe), .host_pins_oe(link.host_pins_oe));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Least cycles from request to interface supply off.
   function automatic int off_min(input mps_pkg::mps_op_t op, input logic mux);
      return (int'(ROUT) + (mux ? int'(MUX) : 0) + (op == mps_pkg::op_off_key ? int'(KOFF) : 0)) * TK - TK;
   endfunction : off_min

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic chk_min(input string what, input int lo, input int got);
      n_checks++;
      if (got < lo) begin
         fail_count++;
         $display("ERROR %s expected >= %0d seen %0d", what, lo, got);
      end
   endtask : chk_min

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step

   task automatic wait_ready(input logic up);
      int i;
      for (i = 0; i < 3000 && !(req_ready === 1'b1 && module_up === up); i++) step(1);
      if (i == 3000) begin
         fail_count++;
         $display("ERROR ready expected 1 seen timeout");
         end_of_test();
      end
   endtask : wait_ready

   task automatic do_op(input mps_pkg::mps_op_t op, input logic arg);
      step(1 + int'(rnd() % 32'h3));
      req_valid = 1'b1;
      req_op = op;
      req_arg = arg;
      step(1);
      req_valid = 1'b0;
      step(2);
   endtask : do_op

   task automatic start(input mps_pkg::mps_op_t op);
      do_op(op, 1'b0);
      wait_ready(1'b1);
      chk_bit("supply up", 1'b1, link.interface_supply);
      chk_bit("pins up", 1'b1, link.dev_pins_oe);
      chk_bit("host ready", 1'b1, host_state === mps_pkg::hs_ready);
      $display("test start done");
   endtask : start

   task automatic power_off(input mps_pkg::mps_op_t op, input logic arg);
      int k0, a0, r0;
      k0 = n_clean;
      a0 = n_abrupt;
      r0 = n_resp;
      do_op(op, arg);
      for (t = 3; t < 3000 && link.interface_supply !== 1'b0; t++) step(1);
      chk_min("off time", off_min(op, arg), t);
      wait_ready(1'b0);
      step(20 + int'(rnd() % 32'h10));
      chk_bit("stays off", 1'b0, link.interface_supply);
      chk_bit("pins float", 1'b0, link.dev_pins_oe);
      chk_bit("backup on", 1'b1, link.backup_clock_supply);
      chk_bit("saved", 1'b1, n_clean == k0 + 1 && n_abrupt == a0);
      chk_bit("ok answer", op == mps_pkg::op_off_cmd, n_resp != r0);
      $display("test power off done");
   endtask : power_off

   initial begin
      step(3);
      sys_rst = 1'b0;
      step(2);
      start(mps_pkg::op_supply_on);
      c0 = n_clean;
      c1 = n_low;
      c2 = n_core;
      do_op(mps_pkg::op_reset_cmd, 1'b0);
      wait_ready(1'b1);
      step(12 * TK);
      chk_bit("supply kept", 1'b1, n_low == c1);
      chk_bit("core restart", 1'b1, n_clean == c0 + 1 && n_core > c2);
      for (int i = 0; i < 2; i++) begin
         power_off(mps_pkg::op_off_cmd, i[0]);
         start(i[0] ? mps_pkg::op_start_rst : mps_pkg::op_start_key);
      end
      power_off(mps_pkg::op_off_key, 1'b0);
      do_op(mps_pkg::op_supply_off, 1'b0);
      step(10);
      chk_bit("not powered", 1'b0, link.backup_clock_supply);
      start(mps_pkg::op_supply_on);
      c0 = n_abrupt;
      c1 = n_low;
      do_op(mps_pkg::op_hw_reset, 1'b0);
      wait_ready(1'b1);
      chk_bit("abrupt reset", 1'b1, n_abrupt == c0 + 1);
      chk_bit("supply cut", 1'b1, n_low > c1);
      do_op(mps_pkg::op_thermal_cmd, 1'b0);
      wait_ready(1'b1);
      for (t = 0; t < 60; t++) begin
         temp_danger = 1'(rnd());
         step(1);
      end
      chk_bit("no thermal off", 1'b1, link.interface_supply);
      temp_danger = 1'b0;
      c0 = n_clean;
      do_op(mps_pkg::op_thermal_cmd, 1'b1);
      wait_ready(1'b1);
      temp_danger = 1'b1;
      for (t = 0; t < 400 && dev_state !== mps_pkg::ds_power_off; t++) step(1);
      step(1);
      chk_bit("thermal off", 1'b1, link.interface_supply === 1'b0 && n_clean == c0 + 1);
      $display("test thermal done");
      c0 = n_fail;
      do_op(mps_pkg::op_reset_cmd, 1'b0);
      wait_ready(1'b1);
      chk_bit("cmd timeout", 1'b1, n_fail == c0 + 1);
      chk_bit("reset restart", 1'b1, link.interface_supply);
      $display("test timeout done");
      end_of_test();
   end
endmodule : module_power_off_reset_sequencer_tb
